//--- design/psbrc_cfg.sv
`timescale 1ns/100ps
// How it works
// - A bus setup write holding any reserved value loads the reset defaults instead.
// - Burst length field: 001 four, 010 eight, 011 sixteen, 111 continuous (default).
// - Wrap bit 0 wraps inside the aligned burst block; 1 counts on linearly.
// - Variable latency: code 010 gives 2 or 4, code 011 gives 3 or 6.
// - Fixed latency: code 010 gives 2 up to 33 MHz, 011 gives 3 up to 52.
// - Deep sleep bit at 0 enables deep sleep and stops all refresh until set.
// - Enabled deep sleep entered when chip enable rises to high, left after 10 us low.
// - After reset the deep sleep bit reads 1, deep sleep disabled.
// - Area field picks full, bottom half/quarter/eighth, none, top half/quarter/eighth.
// - Refreshed ranges align to the array ends, bottom ones start at word zero.
// - Bus bit 14 picks latency kind: 0 variable, 1 fixed from the code.
// - Bus bit 15 picks mode: 1 asynchronous (default), 0 synchronous.
module psbrc_cfg (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire psbrc_pkg::psbrc_pins_t pins,
	input wire logic burst_start,
	input wire logic [psbrc_pkg::AW-1:0] burst_start_addr,
	input wire logic burst_step,
	input wire logic refresh_collision,
	input wire logic [psbrc_pkg::AW-1:0] probe_addr,
	output logic [15:0] bus_setup_reg,
	output logic [15:0] refresh_setup_reg,
	output logic sync_mode_reg,
	output logic [2:0] latency_clocks_reg,
	output logic [7:0] max_clk_mhz_reg,
	output logic [psbrc_pkg::AW-1:0] burst_addr_reg,
	output logic deep_sleep_mode_reg,
	output logic refresh_active_reg,
	output logic [psbrc_pkg::AW-1:0] refresh_lo_reg,
	output logic [psbrc_pkg::AW-1:0] refresh_hi_reg,
	output logic probe_retained_reg
);
	import psbrc_pkg::*;

	// Wrap or linear step of a burst address
	function automatic logic [AW-1:0] burst_next(input logic [AW-1:0] a, input logic [2:0] bl, input logic wrap_n);
		logic [AW-1:0] mask;
		mask = '0;
		if (bl == BL_4) begin
			mask = AW'(3);
		end else if (bl == BL_8) begin
			mask = AW'(7);
		end else if (bl == BL_16) begin
			mask = AW'(15);
		end
		if (wrap_n || mask == '0) begin
			burst_next = a + AW'(1);
		end else begin
			burst_next = (a & ~mask) | ((a + AW'(1)) & mask);
		end
	endfunction : burst_next

	// Lower end of the refreshed word range
	function automatic logic [AW-1:0] area_lo(input logic [2:0] code);
		case (code)
			3'h5: area_lo = HALF_BASE;
			3'h6: area_lo = QUART_BASE;
			3'h7: area_lo = EIGHTH_BASE;
			default: area_lo = '0;
		endcase
	endfunction : area_lo

	// Upper end of the refreshed word range
	function automatic logic [AW-1:0] area_hi(input logic [2:0] code);
		case (code)
			3'h1: area_hi = HALF_END;
			3'h2: area_hi = QUART_END;
			3'h3: area_hi = EIGHTH_END;
			3'h4: area_hi = '0;
			default: area_hi = ADDR_TOP;
		endcase
	endfunction : area_hi

	psbrc_pins_t pins_s;
	logic latch_n_d_reg;
	psbrc_ds_t ds_state_reg;
	psbrc_ds_t ds_state_next;
	logic [WAKE_CW-1:0] wake_cnt_reg;
	logic chip_en_n_d_reg;

	// Pins cross into the clock domain
	psbrc_sync #(.W(PINS_W), .RST_VAL(PINS_IDLE)) u_pin_sync (
		.clk(clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.async_in(pins),
		.sync_out(pins_s)
	);

	// Register write decode on latch rising edge with select high
	wire latch_rise = pins_s.latch_n && !latch_n_d_reg;
	wire cfg_write = latch_rise && pins_s.cr;
	wire wr_bus = cfg_write && (pins_s.addr_hi[SEL_POS] == SEL_BUS);
	wire wr_refresh = cfg_write && (pins_s.addr_hi[SEL_POS] == SEL_REFRESH);
	wire [2:0] wr_blen = pins_s.adq[BLEN_LSB +: 3];
	wire [2:0] wr_lcode = pins_s.adq[LCODE_LSB +: 3];
	wire blen_ok = (wr_blen == BL_4) || (wr_blen == BL_8) || (wr_blen == BL_16) || (wr_blen == BL_CONT);
	wire lcode_ok = (wr_lcode == LC_2) || (wr_lcode == LC_3);
	wire bus_ok = blen_ok && lcode_ok && ((pins_s.adq & BUS_RSVD_MASK) == 16'h0000);
	wire [15:0] bus_wr_val = bus_ok ? pins_s.adq : BUS_RESET;
	wire [15:0] refr_wr_val = pins_s.adq & REFR_KEEP_MASK;

	// Decoded fields of the stored registers
	wire [2:0] cur_blen = bus_setup_reg[BLEN_LSB +: 3];
	wire cur_wrap_n = bus_setup_reg[WRAP_POS];
	wire [2:0] cur_lcode = bus_setup_reg[LCODE_LSB +: 3];
	wire cur_fixed = bus_setup_reg[LKIND_POS];
	wire [2:0] cur_area = refresh_setup_reg[AREA_LSB +: 3];
	wire dsleep_en = !refresh_setup_reg[DSLEEP_POS];

	// Latency selection by kind, code and refresh collision
	wire code3 = (cur_lcode == LC_3);
	wire [2:0] var_lat = code3 ? (refresh_collision ? VAR3_COLL : VAR3_NORM)
		: (refresh_collision ? VAR2_COLL : VAR2_NORM);
	wire [2:0] fix_lat = code3 ? FIX3 : FIX2;
	wire [2:0] lat_next = cur_fixed ? fix_lat : var_lat;
	wire [7:0] mhz_next = cur_fixed ? (code3 ? FIX3_MHZ : FIX2_MHZ) : (code3 ? VAR3_MHZ : VAR2_MHZ);

	// Refresh range and retention of the probed word
	wire [AW-1:0] lo_next = area_lo(cur_area);
	wire [AW-1:0] hi_next = area_hi(cur_area);
	wire refresh_next = (ds_state_next == DS_AWAKE) && !dsleep_en && (cur_area != AREA_NONE);
	wire retained_next = (ds_state_next == DS_AWAKE) && !dsleep_en && (cur_area != AREA_NONE)
		&& (probe_addr >= lo_next) && (probe_addr <= hi_next);
	wire wake_done = (wake_cnt_reg == WAKE_LAST);

	// Deep sleep entry and exit sequencing
	always_comb begin
		ds_state_next = ds_state_reg;
		case (ds_state_reg)
			DS_AWAKE: begin
				if (dsleep_en && pins_s.chip_en_n && !chip_en_n_d_reg) begin
					ds_state_next = DS_ASLEEP;
				end
			end
			DS_ASLEEP: begin
				if (!pins_s.chip_en_n) begin
					ds_state_next = DS_WAKING;
				end
			end
			DS_WAKING: begin
				if (pins_s.chip_en_n) begin
					ds_state_next = DS_ASLEEP;
				end else if (wake_done) begin
					ds_state_next = DS_AWAKE;
				end
			end
			default: ds_state_next = DS_AWAKE;
		endcase
	end

	// Configuration registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_setup_reg <= BUS_RESET;
			refresh_setup_reg <= REFR_RESET;
		end else if (clk_en) begin
			if (wr_bus) begin
				bus_setup_reg <= bus_wr_val;
			end
			if (wr_refresh) begin
				refresh_setup_reg <= refr_wr_val;
			end
		end
	end

	// Deep sleep state and wake counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ds_state_reg <= DS_AWAKE;
			wake_cnt_reg <= '0;
			latch_n_d_reg <= 1'b1;
			chip_en_n_d_reg <= 1'b1;
		end else if (clk_en) begin
			ds_state_reg <= ds_state_next;
			wake_cnt_reg <= (ds_state_reg == DS_WAKING) ? wake_cnt_reg + WAKE_CW'(1) : '0;
			latch_n_d_reg <= pins_s.latch_n;
			chip_en_n_d_reg <= pins_s.chip_en_n;
		end
	end

	// Burst address sequencing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			burst_addr_reg <= '0;
		end else if (clk_en) begin
			if (burst_start) begin
				burst_addr_reg <= burst_start_addr;
			end else if (burst_step) begin
				burst_addr_reg <= burst_next(burst_addr_reg, cur_blen, cur_wrap_n);
			end
		end
	end

	// Registered status outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_mode_reg <= 1'b0;
			latency_clocks_reg <= VAR3_NORM;
			max_clk_mhz_reg <= VAR3_MHZ;
			deep_sleep_mode_reg <= 1'b0;
			refresh_active_reg <= 1'b1;
			refresh_lo_reg <= '0;
			refresh_hi_reg <= ADDR_TOP;
			probe_retained_reg <= 1'b1;
		end else if (clk_en) begin
			sync_mode_reg <= !bus_setup_reg[SYNC_POS];
			latency_clocks_reg <= lat_next;
			max_clk_mhz_reg <= mhz_next;
			deep_sleep_mode_reg <= (ds_state_next != DS_AWAKE);
			refresh_active_reg <= refresh_next;
			refresh_lo_reg <= lo_next;
			refresh_hi_reg <= hi_next;
			probe_retained_reg <= retained_next;
		end
	end

endmodule : psbrc_cfg

//--- design/psbrc_pkg.sv
package psbrc_pkg;

	// Pin group sampled from the controller side
	typedef struct packed {
		logic cr;
		logic latch_n;
		logic chip_en_n;
		logic [4:0] addr_hi;
		logic [15:0] adq;
	} psbrc_pins_t;

	localparam int PINS_W = 24;
	// Idle pin levels: select low, latch and chip enable high
	localparam logic [PINS_W-1:0] PINS_IDLE = 24'h600000;

	// Register select: upper address bit 19 (index 3 of addr_hi)
	localparam int SEL_POS = 3;
	localparam logic SEL_REFRESH = 1'b0;
	localparam logic SEL_BUS = 1'b1;

	// Bus setup register fields
	localparam int SYNC_POS = 15;
	localparam int LKIND_POS = 14;
	localparam int LCODE_LSB = 11;
	localparam int WRAP_POS = 3;
	localparam int BLEN_LSB = 0;
	localparam logic [15:0] BUS_RSVD_MASK = 16'h02d0;
	localparam logic [15:0] BUS_RESET = 16'h9d0f;

	// Refresh setup register fields
	localparam int DSLEEP_POS = 4;
	localparam int AREA_LSB = 0;
	localparam logic [15:0] REFR_KEEP_MASK = 16'h0017;
	localparam logic [15:0] REFR_RESET = 16'h0010;

	// Burst length codes
	localparam logic [2:0] BL_4 = 3'h1;
	localparam logic [2:0] BL_8 = 3'h2;
	localparam logic [2:0] BL_16 = 3'h3;
	localparam logic [2:0] BL_CONT = 3'h7;

	// Latency codes and resulting clocks
	localparam logic [2:0] LC_2 = 3'h2;
	localparam logic [2:0] LC_3 = 3'h3;
	localparam logic [2:0] VAR2_NORM = 3'h2;
	localparam logic [2:0] VAR2_COLL = 3'h4;
	localparam logic [2:0] VAR3_NORM = 3'h3;
	localparam logic [2:0] VAR3_COLL = 3'h6;
	localparam logic [2:0] FIX2 = 3'h2;
	localparam logic [2:0] FIX3 = 3'h3;
	localparam logic [7:0] VAR2_MHZ = 8'h35;
	localparam logic [7:0] VAR3_MHZ = 8'h53;
	localparam logic [7:0] FIX2_MHZ = 8'h21;
	localparam logic [7:0] FIX3_MHZ = 8'h34;

	// Refresh area codes and word ranges
	localparam int AW = 21;
	localparam logic [2:0] AREA_NONE = 3'h4;
	localparam logic [AW-1:0] ADDR_TOP = 21'h1fffff;
	localparam logic [AW-1:0] HALF_END = 21'h0fffff;
	localparam logic [AW-1:0] QUART_END = 21'h07ffff;
	localparam logic [AW-1:0] EIGHTH_END = 21'h03ffff;
	localparam logic [AW-1:0] HALF_BASE = 21'h100000;
	localparam logic [AW-1:0] QUART_BASE = 21'h180000;
	localparam logic [AW-1:0] EIGHTH_BASE = 21'h1c0000;

	// Deep sleep exit: chip enable held low this long
	localparam int CLK_PERIOD_PS = 5000;
	localparam int WAKE_TIME_US = 10;
	localparam int WAKE_CYCLES = (WAKE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WAKE_CW = 12;
	localparam logic [WAKE_CW-1:0] WAKE_LAST = WAKE_CW'(WAKE_CYCLES - 1);

	// Deep sleep states
	typedef enum logic [2:0] {
		DS_AWAKE = 3'b001,
		DS_ASLEEP = 3'b010,
		DS_WAKING = 3'b100
	} psbrc_ds_t;

endpackage : psbrc_pkg

//--- design/psbrc_sync.sv
`timescale 1ns/100ps
module psbrc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;

	// Two-stage synchroniser, first stage read only by the second
	// Resets to the idle pin levels so no false edge follows reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= RST_VAL;
			sync_out <= RST_VAL;
		end else if (clk_en) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : psbrc_sync

//--- bench/psbrc_ctl_model.sv
`timescale 1ns/100ps
module psbrc_ctl_model (
	input wire logic clk,
	output psbrc_pkg::psbrc_pins_t pins
);
	import psbrc_pkg::*;

	// Idle controller: deselected, latch high
	initial begin
		pins = psbrc_pins_t'(PINS_IDLE);
	end

	// Register write by the select-pin method
	task automatic wr(input logic sel, input logic [15:0] data);
		@(negedge clk);
		pins.cr = 1'b1;
		pins.addr_hi = {1'b0, sel, 3'h0};
		pins.adq = data;
		pins.latch_n = 1'b0;
		repeat (3) @(negedge clk);
		pins.latch_n = 1'b1;
		repeat (3) @(negedge clk);
		pins.cr = 1'b0;
		pins.adq = ~data; // Released bus stops showing data
		repeat (2) @(negedge clk);
	endtask : wr

	// Chip enable level, held as long as the caller waits
	task automatic ce(input logic v);
		@(negedge clk);
		pins.chip_en_n = v;
	endtask : ce
endmodule : psbrc_ctl_model

//--- bench/psbrc_cfg_checker.sv
`timescale 1ns/100ps
module psbrc_cfg_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic burst_start,
	input wire logic [psbrc_pkg::AW-1:0] burst_start_addr,
	input wire logic burst_step,
	input wire logic refresh_collision,
	input wire logic [15:0] bus_setup_reg,
	input wire logic [15:0] refresh_setup_reg,
	input wire logic [2:0] latency_clocks_reg,
	input wire logic [7:0] max_clk_mhz_reg,
	input wire logic [psbrc_pkg::AW-1:0] burst_addr_reg,
	input wire logic deep_sleep_mode_reg,
	input wire logic refresh_active_reg,
	input wire logic [psbrc_pkg::AW-1:0] refresh_lo_reg,
	input wire logic [psbrc_pkg::AW-1:0] refresh_hi_reg
);
	import psbrc_pkg::*;
	default clocking @(posedge clk); endclocking
	// A frozen clock enable holds all state, so checks pause with it
	default disable iff (!arst_n || !clk_en);

	// Defaults, latency, burst order and refresh areas
	a_bus_default: assert property ($rose(arst_n) |-> bus_setup_reg == BUS_RESET)
		else $error("bus default wrong");
	a_sleep_default: assert property ($rose(arst_n) |-> refresh_setup_reg[DSLEEP_POS] && !deep_sleep_mode_reg)
		else $error("sleep default wrong");
	a_var_latency: assert property (!bus_setup_reg[LKIND_POS] && bus_setup_reg[13:11] == LC_3 |=>
		latency_clocks_reg == ($past(refresh_collision) ? VAR3_COLL : VAR3_NORM)) else $error("variable latency wrong");
	a_fixed_latency: assert property (bus_setup_reg[LKIND_POS] && bus_setup_reg[13:11] == LC_2 |=>
		latency_clocks_reg == FIX2 && max_clk_mhz_reg == FIX2_MHZ) else $error("fixed latency wrong");
	a_burst_load: assert property (burst_start |=> burst_addr_reg == $past(burst_start_addr))
		else $error("burst load wrong");
	a_wrap_four: assert property (burst_step && !burst_start && bus_setup_reg[2:0] == BL_4 && !bus_setup_reg[WRAP_POS]
		|=> burst_addr_reg == {$past(burst_addr_reg[20:2]), $past(burst_addr_reg[1:0]) + 2'h1}) else $error("wrap wrong");
	a_linear_step: assert property (burst_step && !burst_start && (bus_setup_reg[WRAP_POS] || bus_setup_reg[2:0] == BL_CONT)
		|=> burst_addr_reg == $past(burst_addr_reg) + 21'h1) else $error("linear step wrong");
	a_sleep_norefr: assert property (deep_sleep_mode_reg [*2] |-> !refresh_active_reg)
		else $error("refresh in sleep");
	a_area_none: assert property (refresh_setup_reg[2:0] == AREA_NONE |=> !refresh_active_reg && refresh_hi_reg == '0)
		else $error("area none wrong");
	a_top_quarter: assert property (refresh_setup_reg[2:0] == 3'h6 |=>
		refresh_lo_reg == QUART_BASE && refresh_hi_reg == ADDR_TOP) else $error("top quarter wrong");

	// Main scenarios reached
	c_wrap: cover property (burst_step && !bus_setup_reg[WRAP_POS] && bus_setup_reg[2:0] == BL_4);
	c_sleep: cover property ($rose(deep_sleep_mode_reg));
	c_wake: cover property ($fell(deep_sleep_mode_reg));
endmodule : psbrc_cfg_checker

bind psbrc_cfg psbrc_cfg_checker u_chk (.*);

//--- bench/tb_psram_burst_refresh_config.sv
`timescale 1ns/100ps
module tb_psram_burst_refresh_config;
	import psbrc_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, bstart = 1'b0, bstep = 1'b0, coll = 1'b0, en = 1'b1;
	logic [AW-1:0] saddr = '0, probe = 21'h17ffff, baddr_q, lo_q, hi_q;
	logic [15:0] bus_q, refr_q;
	logic [2:0] lat_q;
	logic [7:0] mhz_q;
	logic sync_q, ds_q, act_q, ret_q;
	logic [21:0] lo, hi;
	psbrc_pins_t pins;
	int err_count = 0, n_checks = 0;
	logic [15:0] wv [7] = '{16'h5501, 16'h5d01, 16'h1509, 16'h1507, 16'h1502, 16'h1503, 16'h1d03};
	logic [10:0] el [7] = '{{FIX2, FIX2_MHZ}, {FIX3, FIX3_MHZ}, {VAR2_COLL, VAR2_MHZ}, {VAR2_COLL, VAR2_MHZ},
		{VAR2_COLL, VAR2_MHZ}, {VAR2_COLL, VAR2_MHZ}, {VAR3_COLL, VAR3_MHZ}};
	logic [AW-1:0] sa [7] = '{21'h103, 21'h0ff, 21'h103, 21'h0ff, 21'h00f, 21'h01f, 21'h010};
	logic [AW-1:0] ea [7] = '{21'h100, 21'h0fc, 21'h104, 21'h100, 21'h008, 21'h010, 21'h011};
	logic [15:0] rv [4] = '{16'h1519, 16'h1d06, 16'h2d0f, 16'h1f0f};

	always #2.5 clk = ~clk;

	psbrc_ctl_model u_ctl (.clk(clk), .pins(pins));
	psbrc_cfg u_dut (.clk(clk), .arst_n(arst_n), .clk_en(en), .pins(pins), .burst_start(bstart),
		.burst_start_addr(saddr), .burst_step(bstep), .refresh_collision(coll), .probe_addr(probe),
		.bus_setup_reg(bus_q), .refresh_setup_reg(refr_q), .sync_mode_reg(sync_q), .latency_clocks_reg(lat_q),
		.max_clk_mhz_reg(mhz_q), .burst_addr_reg(baddr_q), .deep_sleep_mode_reg(ds_q),
		.refresh_active_reg(act_q), .refresh_lo_reg(lo_q), .refresh_hi_reg(hi_q), .probe_retained_reg(ret_q));

	// Compare and count
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One burst load or step, taken at one edge
	task automatic bst(input logic s, input logic [AW-1:0] a);
		@(negedge clk);
		bstart = s;
		bstep = !s;
		saddr = a;
		@(negedge clk);
		bstart = 1'b0;
		bstep = 1'b0;
	endtask : bst

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict();
	end

	// Test sequence
	initial begin
		repeat (20) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		chk({bus_q, refr_q}, {BUS_RESET, REFR_RESET});
		chk({sync_q, lat_q, mhz_q, act_q, hi_q}, {1'b0, VAR3_NORM, VAR3_MHZ, 1'b1, ADDR_TOP});
		$display("test reset done");
		// Variable latency entries expect the collision figures
		coll = 1'b1;
		for (int i = 0; i < 7; i++) begin
			u_ctl.wr(SEL_BUS, wv[i]);
			chk({bus_q, sync_q, lat_q, mhz_q}, {wv[i], 1'b1, el[i]});
			bst(1'b1, sa[i]);
			bst(1'b0, '0);
			chk(baddr_q, ea[i]);
		end
		coll = 1'b0;
		@(negedge clk);
		chk(lat_q, VAR3_NORM);
		for (int i = 0; i < 4; i++) begin
			u_ctl.wr(SEL_BUS, 16'h1d03);
			u_ctl.wr(SEL_BUS, rv[i]);
			chk(bus_q, BUS_RESET);
		end
		// Clock enable low: a write and a burst step are both lost
		en = 1'b0;
		u_ctl.wr(SEL_BUS, 16'h1d03);
		bst(1'b0, '0);
		en = 1'b1;
		chk({bus_q, baddr_q}, {BUS_RESET, ea[6]});
		$display("test bus setup done");
		for (int c = 0; c < 8; c++) begin
			probe = 21'h03ffff + 21'(c) * 21'h040000;
			u_ctl.wr(SEL_REFRESH, 16'h0010 | 16'(c));
			lo = (c > 4) ? 22'h200000 - (22'h200000 >> (c - 4)) : '0;
			hi = (c == 4) ? '0 : (c > 0 && c < 4) ? (22'h200000 >> c) - 22'h1 : 22'h1fffff;
			chk(refr_q, 16'h0010 | 16'(c));
			chk({act_q, lo_q, hi_q}, {c != 4, lo[20:0], hi[20:0]});
			chk(ret_q, (c != 4) && (probe >= lo[20:0]) && (probe <= hi[20:0]));
		end
		$display("test refresh area done");
		u_ctl.wr(SEL_REFRESH, 16'h0000);
		u_ctl.ce(1'b0);
		repeat (5) @(negedge clk);
		chk(ds_q, 1'b0);
		u_ctl.ce(1'b1);
		repeat (5) @(negedge clk);
		chk({ds_q, act_q}, 2'b10);
		u_ctl.ce(1'b0);
		repeat (1000) @(negedge clk);
		u_ctl.ce(1'b1);
		repeat (5) @(negedge clk);
		u_ctl.ce(1'b0);
		repeat (1990) @(negedge clk);
		chk(ds_q, 1'b1);
		repeat (20) @(negedge clk);
		chk({ds_q, act_q}, 2'b00);
		u_ctl.wr(SEL_REFRESH, 16'h0010);
		chk(act_q, 1'b1);
		$display("test deep sleep done");
		print_verdict();
	end
endmodule : tb_psram_burst_refresh_config
